// ===== rtl/ocpa_pkg.sv
// Constants, register map and bus carrier for the output compare / pulse accumulator block
// Summary of operation
// - Compare value registers are 16-bit read-write; idle ones act as plain storage.
// - A channel's compare flag sets whenever the counter equals its compare value.
// - First flag register bits clear only by writing one; zero leaves them.
// - Shared register is compare five when selected; its shared flag sets on match.
// - Channels one to four request interrupt when flag and matching enable are set.
// - Channel five interrupt needs compare five selected, enable set and flag set.
// - Channels two to five pin action: 00 none, 01 toggle, 10 low, 11 high.
// - Writing one to a force bit fires that action at the next count step.
// - Forced compares drive pins like matches but set no flag, request no interrupt.
// - Channel one mask bits map to port A bits seven to three.
// - On channel one match, masked pins take the channel one data bits.
// - Event mode counts each selected edge; input rate at most half the clock.
// - Gated mode counts clock over 64 while input is not at inhibit level.
// - Accumulator input follows port A bit seven pin, even when driven as output.
// - Accumulator runs only while its enable bit is one.
// - Mode and edge bits: 00 falling, 01 rising, 10 inhibit low, 11 inhibit high.
// - Overflow flag sets each time the count wraps from ff to 00.
// - Overflow requests interrupt when enabled; flag cleared by writing one.
// - Edge flag sets on every selected edge; interrupt when enabled; write one clears.
// - Accumulator count survives reset and is readable and writable any time.
// - Increments and software reads never collide, so reads are stable.
// - Compare value registers reset to all ones.
// - Each enabled channel compares against the counter once per count step.
// - Pin action happens on every match even with the flag still set.
package ocpa_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ocpa_bus_req_type;

    // Register offsets
    localparam logic [7:0] OFS_PORT_A_DATA   = 8'h00;
    localparam logic [7:0] OFS_PORT_A_DIR    = 8'h01;
    localparam logic [7:0] OFS_COMPARE_FORCE = 8'h0b;
    localparam logic [7:0] OFS_CH1_PIN_MASK  = 8'h0c;
    localparam logic [7:0] OFS_CH1_PIN_DATA  = 8'h0d;
    localparam logic [7:0] OFS_CMP_FIRST     = 8'h16;
    localparam logic [7:0] OFS_CMP_LAST      = 8'h1f;
    localparam logic [7:0] OFS_PIN_ACTION    = 8'h20;
    localparam logic [7:0] OFS_INT_EN_FIRST  = 8'h22;
    localparam logic [7:0] OFS_FLAGS_FIRST   = 8'h23;
    localparam logic [7:0] OFS_INT_EN_SECOND = 8'h24;
    localparam logic [7:0] OFS_FLAGS_SECOND  = 8'h25;
    localparam logic [7:0] OFS_ACC_CONTROL   = 8'h26;
    localparam logic [7:0] OFS_ACC_COUNT     = 8'h27;

    localparam int NUM_CH = 5;

    // Field positions
    localparam int BIT_CH1_FLAG      = 7;
    localparam int BIT_LOW_PIN       = 3;
    localparam int BIT_ACC_PIN       = 7;
    localparam int BIT_ACC_OVF       = 5;
    localparam int BIT_ACC_EDGE      = 4;
    localparam int BIT_ACC_ENABLE    = 6;
    localparam int BIT_ACC_GATED     = 5;
    localparam int BIT_ACC_EDGE_SEL  = 4;
    localparam int BIT_CAPTURE4_SEL  = 2;

    // Reset values
    localparam logic [15:0] RST_COMPARE_VALUE = 16'hffff;
    localparam logic [7:0]  RST_REG8          = 8'h00;
    localparam logic [4:0]  RST_CH_VEC        = 5'h00;

    // Gated mode time base
    localparam int         ACC_GATE_DIV = 64;
    localparam int         ACC_PRE_W    = $clog2(ACC_GATE_DIV);
    localparam logic [7:0] ACC_WRAP     = 8'hff;

endpackage : ocpa_pkg

// ===== rtl/ocpa_output_compare_pulse_accumulator.sv
// Five-channel output compare with port A pin actions and an 8-bit pulse accumulator
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ocpa_output_compare_pulse_accumulator (
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_n_i,
    // Free-running counter from the timer core
    input  wire logic [15:0]                tcnt_i,
    input  wire logic                       count_step_i,
    // Register port
    input  wire ocpa_pkg::ocpa_bus_req_type bus_req_i,
    output logic [7:0]                      rd_data_o,
    // Port A pins
    input  wire logic [7:0]                 port_a_in_i,
    output logic [7:0]                      port_a_out_o,
    output logic [7:0]                      port_a_oe_o,
    // Interrupt requests
    output logic [4:0]                      compare_int_req_o,
    output logic                            acc_overflow_int_req_o,
    output logic                            acc_edge_int_req_o
);

    localparam int NCH = ocpa_pkg::NUM_CH;

    // Reset synchroniser
    logic                 rst_meta_r;
    logic                 rst_sync_r;

    // Compare channels
    logic [15:0]          cmp_r [NCH];
    logic [NCH-1:0]       ch_enable;
    logic [NCH-1:0]       match;
    logic [NCH-1:0]       force_fire;
    logic [NCH-1:0]       act;
    logic [NCH-1:0]       force_pend_r;
    logic [NCH-1:0]       force_pend_nxt;
    logic [NCH-1:0]       cmp_flag_r;
    logic [NCH-1:0]       cmp_flag_nxt;
    logic [NCH-1:0]       cmp_int_en_r;
    logic [NCH-1:0]       wr_vec;

    // Port A and control
    logic [7:0]           port_a_data_r;
    logic [7:0]           port_a_data_nxt;
    logic [7:0]           port_a_dir_r;
    logic [7:0]           pin_action_r;
    logic [7:0]           ch1_mask_r;
    logic [7:0]           ch1_data_r;
    logic [7:0]           acc_ctrl_r;

    // Pulse accumulator
    logic [7:0]           acc_count_r;
    logic                 acc_ovf_flag_r;
    logic                 acc_edge_flag_r;
    logic                 acc_ovf_int_en_r;
    logic                 acc_edge_int_en_r;
    logic                 acc_pin_prev_r;
    logic [ocpa_pkg::ACC_PRE_W-1:0] acc_pre_r;
    logic                 acc_pin;
    logic                 acc_rise;
    logic                 acc_fall;
    logic                 acc_sel_edge;
    logic                 acc_gate_tick;
    logic                 acc_inc;
    logic                 acc_overflow;
    logic                 acc_edge_event;

    // Register port
    logic [7:0]           rd_data_nxt;
    logic [2:0]           cmp_rd_idx;
    logic                 wr_force;
    logic                 wr_flags1;
    logic                 wr_flags2;
    logic                 wr_count;

    // Reset release through two flops
    // Assert is asynchronous; only the release waits for the clock
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Writes with side effects
    assign wr_force  = bus_req_i.wr && bus_req_i.addr == ocpa_pkg::OFS_COMPARE_FORCE;
    assign wr_flags1 = bus_req_i.wr && bus_req_i.addr == ocpa_pkg::OFS_FLAGS_FIRST;
    assign wr_flags2 = bus_req_i.wr && bus_req_i.addr == ocpa_pkg::OFS_FLAGS_SECOND;
    assign wr_count  = bus_req_i.wr && bus_req_i.addr == ocpa_pkg::OFS_ACC_COUNT;

    // Channel i lives at register bit 7-i in the flag, enable and force registers
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            localparam logic [7:0] OFS_HI = 8'(ocpa_pkg::OFS_CMP_FIRST + 2 * gi);
            localparam logic [7:0] OFS_LO = 8'(ocpa_pkg::OFS_CMP_FIRST + 2 * gi + 1);

            // Compare value kept regardless of use, so it doubles as storage
            // Bytes land one at a time; a half-written value can match
            always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
                if (!rst_sync_r) begin
                    cmp_r[gi] <= ocpa_pkg::RST_COMPARE_VALUE;
                end else if (bus_req_i.wr && bus_req_i.addr == OFS_HI) begin
                    cmp_r[gi][15:8] <= bus_req_i.wdata;
                end else if (bus_req_i.wr && bus_req_i.addr == OFS_LO) begin
                    cmp_r[gi][7:0] <= bus_req_i.wdata;
                end
            end

            // Channel five only compares when port A bit three is not a capture input
            if (gi == NCH - 1) begin : g_shared
                assign ch_enable[gi] = !acc_ctrl_r[ocpa_pkg::BIT_CAPTURE4_SEL];
            end else begin : g_plain
                assign ch_enable[gi] = 1'b1;
            end

            // Matched once per counter value, only on the step that loads it
            assign match[gi] = ch_enable[gi] && count_step_i
                               && tcnt_i == cmp_r[gi];

            // Armed force fires on the next count step
            assign force_fire[gi] = force_pend_r[gi] && count_step_i;
            assign act[gi]        = match[gi] || force_fire[gi];
            assign wr_vec[gi]     = bus_req_i.wdata[ocpa_pkg::BIT_CH1_FLAG - gi];
        end
    endgenerate

    // Force bits: a write during the firing step waits for the next one
    always_comb begin
        force_pend_nxt = force_pend_r & ~force_fire;

        if (wr_force) begin
            force_pend_nxt = force_pend_nxt | wr_vec;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            force_pend_r <= ocpa_pkg::RST_CH_VEC;
        end else begin
            force_pend_r <= force_pend_nxt;
        end
    end

    // Match flags: only real matches set them; a set in the clearing cycle wins
    always_comb begin
        cmp_flag_nxt = cmp_flag_r;
        if (wr_flags1) begin
            cmp_flag_nxt = cmp_flag_r & ~wr_vec;
        end

        cmp_flag_nxt = cmp_flag_nxt | match;
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cmp_flag_r <= ocpa_pkg::RST_CH_VEC;
        end else begin
            cmp_flag_r <= cmp_flag_nxt;
        end
    end

    // Port A data: channel one first, then the per-channel action on its own pin
    always_comb begin
        port_a_data_nxt = port_a_data_r;
        if (bus_req_i.wr && bus_req_i.addr == ocpa_pkg::OFS_PORT_A_DATA) begin
            port_a_data_nxt = bus_req_i.wdata;
        end

        // Hardware beats a same-cycle software write
        if (act[0]) begin
            for (int b = ocpa_pkg::BIT_LOW_PIN; b < 8; b++) begin
                if (ch1_mask_r[b]) begin
                    port_a_data_nxt[b] = ch1_data_r[b];
                end
            end
        end

        // Channels two to five beat channel one; toggle uses the old level
        for (int k = 1; k < NCH; k++) begin
            if (act[k]) begin
                case (pin_action_r[9-2*k -: 2])
                    2'b01:   port_a_data_nxt[7-k] = ~port_a_data_r[7-k];
                    2'b10:   port_a_data_nxt[7-k] = 1'b0;
                    2'b11:   port_a_data_nxt[7-k] = 1'b1;
                    default: port_a_data_nxt[7-k] = port_a_data_nxt[7-k];
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            port_a_data_r <= ocpa_pkg::RST_REG8;
        end else begin
            port_a_data_r <= port_a_data_nxt;
        end
    end

    // Plain control registers
    // Enables stored by channel, not by bit
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            port_a_dir_r      <= ocpa_pkg::RST_REG8;
            pin_action_r      <= ocpa_pkg::RST_REG8;
            ch1_mask_r        <= ocpa_pkg::RST_REG8;
            ch1_data_r        <= ocpa_pkg::RST_REG8;
            acc_ctrl_r        <= ocpa_pkg::RST_REG8;
            cmp_int_en_r      <= ocpa_pkg::RST_CH_VEC;
            acc_ovf_int_en_r  <= 1'b0;
            acc_edge_int_en_r <= 1'b0;
        end else if (bus_req_i.wr) begin
            if (bus_req_i.addr == ocpa_pkg::OFS_PORT_A_DIR) begin
                port_a_dir_r <= bus_req_i.wdata;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_PIN_ACTION) begin
                pin_action_r <= bus_req_i.wdata;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_CH1_PIN_MASK) begin
                ch1_mask_r <= bus_req_i.wdata;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_CH1_PIN_DATA) begin
                ch1_data_r <= bus_req_i.wdata;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_ACC_CONTROL) begin
                acc_ctrl_r <= bus_req_i.wdata;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_INT_EN_FIRST) begin
                cmp_int_en_r <= wr_vec;
            end else if (bus_req_i.addr == ocpa_pkg::OFS_INT_EN_SECOND) begin
                acc_ovf_int_en_r  <= bus_req_i.wdata[ocpa_pkg::BIT_ACC_OVF];
                acc_edge_int_en_r <= bus_req_i.wdata[ocpa_pkg::BIT_ACC_EDGE];
            end
        end
    end

    // Pulse accumulator: input is the pin itself, whatever the direction
    assign acc_pin  = port_a_in_i[ocpa_pkg::BIT_ACC_PIN];
    assign acc_rise = acc_pin && !acc_pin_prev_r;
    assign acc_fall = !acc_pin && acc_pin_prev_r;

    // Edge polarity also marks the end of a gated interval in gated mode
    assign acc_sel_edge = acc_ctrl_r[ocpa_pkg::BIT_ACC_EDGE_SEL] ? acc_rise : acc_fall;

    assign acc_gate_tick = &acc_pre_r;
    assign acc_edge_event = acc_ctrl_r[ocpa_pkg::BIT_ACC_ENABLE] && acc_sel_edge;

    // Edges seen cycle by cycle, so pulses faster than half the clock are missed
    always_comb begin
        acc_inc = 1'b0;
        if (acc_ctrl_r[ocpa_pkg::BIT_ACC_ENABLE]) begin
            if (!acc_ctrl_r[ocpa_pkg::BIT_ACC_GATED]) begin
                acc_inc = acc_sel_edge;
            end else begin
                acc_inc = acc_gate_tick
                          && acc_pin != acc_ctrl_r[ocpa_pkg::BIT_ACC_EDGE_SEL];
            end
        end
    end

    // A same-cycle count write cancels the wrap
    assign acc_overflow = acc_inc && !wr_count && acc_count_r == ocpa_pkg::ACC_WRAP;

    // Prescaler free-runs from reset
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            acc_pin_prev_r <= 1'b0;
            acc_pre_r      <= '0;
        end else begin
            acc_pin_prev_r <= acc_pin;
            acc_pre_r      <= acc_pre_r + 1'b1;
        end
    end

    // Count has no reset; a software write beats a same-cycle increment.
    // Reads capture the settled value before this edge, so they never see a half update.
    always_ff @(posedge sys_clk_i) begin
        if (wr_count) begin
            acc_count_r <= bus_req_i.wdata;
        end else if (acc_inc) begin
            acc_count_r <= acc_count_r + 8'h01;
        end
    end

    // Second flag register: set beats a same-cycle clear
    // Written zeros leave both flags alone
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            acc_ovf_flag_r  <= 1'b0;
            acc_edge_flag_r <= 1'b0;
        end else begin
            if (acc_overflow) begin
                acc_ovf_flag_r <= 1'b1;
            end else if (wr_flags2 && bus_req_i.wdata[ocpa_pkg::BIT_ACC_OVF]) begin
                acc_ovf_flag_r <= 1'b0;
            end
            if (acc_edge_event) begin
                acc_edge_flag_r <= 1'b1;
            end else if (wr_flags2 && bus_req_i.wdata[ocpa_pkg::BIT_ACC_EDGE]) begin
                acc_edge_flag_r <= 1'b0;
            end
        end
    end

    // Interrupt requests, registered from the current flags
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            compare_int_req_o      <= ocpa_pkg::RST_CH_VEC;
            acc_overflow_int_req_o <= 1'b0;
            acc_edge_int_req_o     <= 1'b0;
        end else begin
            // Dropped while channel five's pin is a capture input
            compare_int_req_o      <= cmp_flag_r & cmp_int_en_r & ch_enable;
            acc_overflow_int_req_o <= acc_ovf_flag_r && acc_ovf_int_en_r;
            acc_edge_int_req_o     <= acc_edge_flag_r && acc_edge_int_en_r;
        end
    end

    // Read mux; the force register always reads zero
    assign cmp_rd_idx = 3'((bus_req_i.addr - ocpa_pkg::OFS_CMP_FIRST) >> 1);

    // Unmapped and reserved bits read zero
    always_comb begin
        rd_data_nxt = 8'h00;
        if (!bus_req_i.rd) begin
            rd_data_nxt = 8'h00;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_PORT_A_DATA) begin
            rd_data_nxt = port_a_data_r;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_PORT_A_DIR) begin
            rd_data_nxt = port_a_dir_r;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_CH1_PIN_MASK) begin
            rd_data_nxt = ch1_mask_r & 8'hf8;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_CH1_PIN_DATA) begin
            rd_data_nxt = ch1_data_r & 8'hf8;
        end else if (bus_req_i.addr >= ocpa_pkg::OFS_CMP_FIRST
                     && bus_req_i.addr <= ocpa_pkg::OFS_CMP_LAST) begin
            rd_data_nxt = bus_req_i.addr[0] ? cmp_r[cmp_rd_idx][7:0]
                                            : cmp_r[cmp_rd_idx][15:8];
        end else if (bus_req_i.addr == ocpa_pkg::OFS_PIN_ACTION) begin
            rd_data_nxt = pin_action_r;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_INT_EN_FIRST) begin
            rd_data_nxt = {cmp_int_en_r[0], cmp_int_en_r[1], cmp_int_en_r[2],
                           cmp_int_en_r[3], cmp_int_en_r[4], 3'h0};
        end else if (bus_req_i.addr == ocpa_pkg::OFS_FLAGS_FIRST) begin
            rd_data_nxt = {cmp_flag_r[0], cmp_flag_r[1], cmp_flag_r[2],
                           cmp_flag_r[3], cmp_flag_r[4], 3'h0};
        end else if (bus_req_i.addr == ocpa_pkg::OFS_INT_EN_SECOND) begin
            rd_data_nxt = {2'h0, acc_ovf_int_en_r, acc_edge_int_en_r, 4'h0};
        end else if (bus_req_i.addr == ocpa_pkg::OFS_FLAGS_SECOND) begin
            rd_data_nxt = {2'h0, acc_ovf_flag_r, acc_edge_flag_r, 4'h0};
        end else if (bus_req_i.addr == ocpa_pkg::OFS_ACC_CONTROL) begin
            rd_data_nxt = acc_ctrl_r & 8'h74;
        end else if (bus_req_i.addr == ocpa_pkg::OFS_ACC_COUNT) begin
            rd_data_nxt = acc_count_r;
        end
    end

    // Outputs straight from flops
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rd_data_o    <= 8'h00;
            port_a_out_o <= 8'h00;
            port_a_oe_o  <= 8'h00;
        end else begin
            rd_data_o    <= rd_data_nxt;
            port_a_out_o <= port_a_data_nxt;
            port_a_oe_o  <= port_a_dir_r;
        end
    end

endmodule // ocpa_output_compare_pulse_accumulator
`default_nettype wire

// ===== tb/ocpa_checker.sv
// Port-level assertions for the compare and accumulator block
`timescale 1ns/10ps
`default_nettype none
module ocpa_checker (
    // Clock, reset and inputs
    input wire logic                       sys_clk_i,
    input wire logic                       reset_n_i,
    input wire logic [15:0]                tcnt_i,
    input wire logic                       count_step_i,
    input wire ocpa_pkg::ocpa_bus_req_type bus_req_i,
    input wire logic [7:0]                 port_a_in_i,
    // Outputs
    input wire logic [7:0]                 rd_data_o,
    input wire logic [7:0]                 port_a_out_o,
    input wire logic [7:0]                 port_a_oe_o,
    input wire logic [4:0]                 compare_int_req_o,
    input wire logic                       acc_overflow_int_req_o,
    input wire logic                       acc_edge_int_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_rd_idle_zero: assert property (!$past(bus_req_i.rd) |-> rd_data_o == 8'h00)
        else $error("read data outside its slot");
    chk_force_rd_zero: assert property (bus_req_i.rd && bus_req_i.addr == 8'h0b
        |=> rd_data_o == 8'h00) else $error("force register read not zero");
    chk_unmapped_rd: assert property (bus_req_i.rd && bus_req_i.addr == 8'h40
        |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
    chk_pin_cause: assert property ($changed(port_a_out_o)
        |-> $past(count_step_i) || $past(bus_req_i.wr))
        else $error("port pins moved without step or write");
    chk_low_pins_sw: assert property ($changed(port_a_out_o[2:0])
        |-> $past(bus_req_i.wr && bus_req_i.addr == 8'h00))
        else $error("low port pins moved by compare");
    chk_cmp_int_cause: assert property (
        (compare_int_req_o & ~$past(compare_int_req_o)) != 5'h00
        |-> $past(count_step_i, 2) || $past(bus_req_i.wr, 2))
        else $error("compare request without match");
    chk_flag_clr_int: assert property (bus_req_i.wr && bus_req_i.addr == 8'h23
        && bus_req_i.wdata == 8'hff && !count_step_i |-> ##2 compare_int_req_o == 5'h00)
        else $error("compare request survives clear");
    chk_edge_int_cause: assert property ($rose(acc_edge_int_req_o)
        |-> $past(port_a_in_i[7], 2) != $past(port_a_in_i[7], 3) || $past(bus_req_i.wr, 2))
        else $error("edge request without pin edge");
endmodule // ocpa_checker

bind ocpa_output_compare_pulse_accumulator ocpa_checker u_chk (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .tcnt_i(tcnt_i), .count_step_i(count_step_i),
    .bus_req_i(bus_req_i), .port_a_in_i(port_a_in_i), .rd_data_o(rd_data_o),
    .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
    .compare_int_req_o(compare_int_req_o), .acc_overflow_int_req_o(acc_overflow_int_req_o),
    .acc_edge_int_req_o(acc_edge_int_req_o));
`default_nettype wire

// ===== tb/ocpa_pin_model.sv
// Port A pin model: each pin shows the block's drive or the outside level
`timescale 1ns/10ps
`default_nettype none
module ocpa_pin_model (
    // Block side
    input  wire logic [7:0] port_a_out_i,
    input  wire logic [7:0] port_a_oe_i,
    // Outside world
    input  wire logic [7:0] ext_level_i,
    output logic [7:0]      pin_o
);
    // Pins read back what is on the wire, driven or not
    assign pin_o = (port_a_oe_i & port_a_out_i) | (~port_a_oe_i & ext_level_i);
endmodule // ocpa_pin_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the compare and accumulator block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                       sys_clk_i = 1'b0;
    logic                       reset_n_i = 1'b0;
    logic [15:0]                tcnt_i = 16'h0000;
    logic                       count_step_i = 1'b0;
    ocpa_pkg::ocpa_bus_req_type bus_req_i = '0;
    logic [7:0]                 ext_lvl = 8'h00;
    logic [7:0]                 rd_data_o, port_a_in_i, port_a_out_o, port_a_oe_o;
    logic [4:0]                 compare_int_req_o;
    logic                       acc_overflow_int_req_o, acc_edge_int_req_o;
    logic [31:0]                seed = 32'h00001704;
    int                         mismatches = 0, n_tests = 0, cyc = 0;
    int                         mdl [int];

    ocpa_output_compare_pulse_accumulator dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .tcnt_i(tcnt_i), .count_step_i(count_step_i), .bus_req_i(bus_req_i),
        .rd_data_o(rd_data_o), .port_a_in_i(port_a_in_i), .port_a_out_o(port_a_out_o),
        .port_a_oe_o(port_a_oe_o), .compare_int_req_o(compare_int_req_o),
        .acc_overflow_int_req_o(acc_overflow_int_req_o), .acc_edge_int_req_o(acc_edge_int_req_o));
    ocpa_pin_model pm (.port_a_out_i(port_a_out_o), .port_a_oe_i(port_a_oe_o),
        .ext_level_i(ext_lvl), .pin_o(port_a_in_i));

    initial forever #2.5 sys_clk_i = ~sys_clk_i;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang ends the run as a failure
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus_req_i <= '0;
        mdl[a] = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        bus_req_i <= '0;
        #1 chk($sformatf("reg %h", a), exp, rd_data_o);
    endtask

    // One counter step, then pins and requests once the request has had time to follow
    task automatic tick(input logic [15:0] t, input logic [7:0] ep, input logic [7:0] ei);
        @(posedge sys_clk_i);
        tcnt_i <= t;
        count_step_i <= 1'b1;
        @(posedge sys_clk_i);
        count_step_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1 chk("port a out", ep, port_a_out_o);
        chk("compare irq", ei, {3'b000, compare_int_req_o});
    endtask

    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        for (int a = 8'h16; a <= 8'h1f; a++) rd(8'(a), 8'hff);
        rd(8'h23, 8'h00);
        wr(8'h40, 8'h5a);
        rd(8'h40, 8'h00);
        rd(8'h0b, 8'h00);
        for (int a = 8'h16; a <= 8'h1f; a++) wr(8'(a), 8'(xs()));
        for (int a = 8'h16; a <= 8'h1f; a++) rd(8'(a), 8'(mdl[a]));
        for (int a = 8'h16; a <= 8'h1f; a++) wr(8'(a), a[0] ? 8'h34 : 8'h12);
        wr(8'h01, 8'hf8);
        wr(8'h0c, 8'h80);
        #1 chk("port a oe", 8'hf8, port_a_oe_o);
        wr(8'h0d, 8'h80);
        wr(8'h20, 8'h6c);
        wr(8'h22, 8'hf8);
        rd(8'h22, 8'hf8);
        tick(16'h1234, 8'hd0, 8'h1f);
        rd(8'h23, 8'hf8);
        wr(8'h23, 8'h00);
        rd(8'h23, 8'hf8);
        wr(8'h26, 8'h04);
        rd(8'h26, 8'h04);
        wr(8'h23, 8'hff);
        tick(16'h1234, 8'h90, 8'h0f);
        rd(8'h23, 8'hf0);
        wr(8'h23, 8'hff);
        wr(8'h0d, 8'h00);
        wr(8'h20, 8'h68);
        // The toggling channel is left out of the force
        wr(8'h0b, 8'h90);
        #1 chk("port a out", 8'h90, port_a_out_o);
        tick(16'h0001, 8'h00, 8'h00);
        rd(8'h23, 8'h00);
        wr(8'h00, 8'h07);
        @(posedge sys_clk_i);
        #1 chk("port a out", 8'h07, port_a_out_o);
        rd(8'h00, 8'h07);
        wr(8'h01, 8'h78);
        wr(8'h24, 8'h30);
        for (int m = 0; m < 5; m++) begin
            int n;
            n = (m == 4) ? 0 : (m == 1) ? 2 : 3;
            ext_lvl[7] <= (m != 2);
            repeat (4) @(posedge sys_clk_i);
            wr(8'h26, (m == 4) ? 8'h10 : 8'(8'h40 | (m << 4)));
            wr(8'h25, 8'h30);
            wr(8'h27, 8'hfe);
            if (m == 2 || m == 3) begin
                @(posedge sys_clk_i) ext_lvl[7] <= ~ext_lvl[7];
                repeat (192) @(posedge sys_clk_i);
                ext_lvl[7] <= ~ext_lvl[7];
            end else begin
                repeat (5) begin
                    repeat (2) @(posedge sys_clk_i);
                    ext_lvl[7] <= ~ext_lvl[7];
                end
            end
            repeat (4) @(posedge sys_clk_i);
            rd(8'h27, 8'(8'hfe + n));
            rd(8'h25, (m == 4) ? 8'h00 : 8'h30);
            chk("acc irq", (m == 4) ? 8'h00 : 8'h03,
                {6'h00, acc_overflow_int_req_o, acc_edge_int_req_o});
        end
        wr(8'h25, 8'h30);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("acc irq", 8'h00, {6'h00, acc_overflow_int_req_o, acc_edge_int_req_o});
        chk("port a oe", 8'h78, port_a_oe_o);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
